/* csl_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module csl_dev (
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic CLK_EN_IN,
  csl_link_if.dev LINK,
  input wire logic [13:0] ADC_SAMPLE_IN,
  output logic [13:0] DAC_SAMPLE_OUT,
  output logic DAC_STROBE_OUT,
  output logic [13:0] CFG_OUT,
  output logic [13:0] RATE_A_OUT,
  output logic [13:0] RATE_B_OUT
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_SHIFT = 4'b0010,
    S_FRAME_UP = 4'b0100,
    S_END = 4'b1000
  } csl_dev_state_e;

  // Synchronisers for pins from the host
  logic [1:0] mclk_sync, rst_sync, wsel_sync, txd_sync;
  logic mclk_prev;  // Last synchronised master clock
  logic mclk_rise;
  logic dev_rst;    // Converter held in reset
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      mclk_sync <= 2'h0;
      rst_sync <= 2'h0;
      wsel_sync <= 2'h0;
      txd_sync <= 2'h0;
      mclk_prev <= 1'b0;
    end else if (CLK_EN_IN) begin
      mclk_sync <= {mclk_sync[0], LINK.master_clk};
      rst_sync <= {rst_sync[0], LINK.reset_n};
      wsel_sync <= {wsel_sync[0], LINK.word_sel};
      txd_sync <= {txd_sync[0], LINK.tx_data};
      mclk_prev <= mclk_sync[1];
    end
  end
  assign mclk_rise = mclk_sync[1] & ~mclk_prev;
  assign dev_rst = ~rst_sync[1];

  // Shift clock divider from master clock edges
  logic [2:0] div_cnt;
  logic sclk;      // Shift clock level driven out
  logic sclk_fall; // Launch point, one per shift period
  logic sclk_rise; // Sample point
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      div_cnt <= 3'h0;
      sclk <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (dev_rst) begin
        div_cnt <= 3'h0;
        sclk <= 1'b0;
      end else if (mclk_rise) begin
        if (div_cnt == 3'(csl_pkg::SCLK_HALF - 1)) begin
          div_cnt <= 3'h0;
          sclk <= ~sclk;
        end else begin
          div_cnt <= div_cnt + 3'h1;
        end
      end
    end
  end
  assign sclk_fall = mclk_rise && div_cnt == 3'(csl_pkg::SCLK_HALF - 1) && sclk;
  assign sclk_rise = mclk_rise && div_cnt == 3'(csl_pkg::SCLK_HALF - 1) && !sclk;

  // Configuration registers, loaded by secondary control words
  logic [13:0] cfg, rate_a, rate_b;
  logic escape_seen;        // Next received word is control
  logic [15:0] rx_word;     // Word collected from host
  logic rx_done;            // One-cycle: host word complete
  logic async_mode;
  assign async_mode = cfg[csl_pkg::CFG_ASYNC_BIT];
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cfg <= csl_pkg::CFG_RESET;
      rate_a <= csl_pkg::RATE_A_RESET;
      rate_b <= csl_pkg::RATE_B_RESET;
      escape_seen <= 1'b0;
      DAC_SAMPLE_OUT <= 14'h0;
      DAC_STROBE_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      DAC_STROBE_OUT <= 1'b0;
      if (dev_rst) begin
        // Defaults: filters on, synchronous, base rate dividers
        cfg <= csl_pkg::CFG_RESET;
        rate_a <= csl_pkg::RATE_A_RESET;
        rate_b <= csl_pkg::RATE_B_RESET;
        escape_seen <= 1'b0;
      end else if (rx_done) begin
        if (escape_seen) begin
          escape_seen <= 1'b0;
          // Kind taken from the two low bits
          case (rx_word[1:0])
            csl_pkg::SEC_RATE_A: rate_a <= rx_word[15:2];
            csl_pkg::SEC_RATE_B: rate_b <= rx_word[15:2];
            // Filter bit sits where it sits in a whole config word
            csl_pkg::SEC_FILTER: cfg[csl_pkg::CFG_FILT_BIT] <= rx_word[csl_pkg::CTRL_W + csl_pkg::CFG_FILT_BIT];
            csl_pkg::SEC_CONFIG: cfg <= rx_word[15:2];
            default: cfg <= cfg;
          endcase
        end else begin
          // Escape only arms; the sample in it is still played
          escape_seen <= (rx_word[1:0] == csl_pkg::ESCAPE_CODE);
          DAC_SAMPLE_OUT <= rx_word[15:2];
          DAC_STROBE_OUT <= 1'b1;
        end
      end
    end
  end
  assign CFG_OUT = cfg;
  assign RATE_A_OUT = rate_a;
  assign RATE_B_OUT = rate_b;

  // Frame timing: both sections share one sequencer; async drops alternate receive frames
  logic [7:0] gap_cnt;
  logic frame_go;
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      gap_cnt <= 8'h0;
    end else if (CLK_EN_IN) begin
      if (dev_rst) begin
        gap_cnt <= 8'h0;
      end else if (sclk_fall) begin
        gap_cnt <= (gap_cnt == csl_pkg::FRAME_GAP_T - 8'h1) ? 8'h0 : gap_cnt + 8'h1;
      end
    end
  end
  assign frame_go = sclk_fall && gap_cnt == 8'h0;

  csl_dev_state_e state;
  logic [3:0] bit_cnt;
  logic [15:0] tx_shift;   // Word to host
  logic tx_fs_n, rx_fs_n, end_n, rxd;
  logic rx_lag;            // Async: toggles each frame; receive frame skipped while set
  // Sequencer: frame low, 16 bits, frame high, end pulse
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      tx_shift <= 16'h0;
      rx_word <= 16'h0;
      rx_done <= 1'b0;
      tx_fs_n <= 1'b1;
      rx_fs_n <= 1'b1;
      end_n <= 1'b1;
      rxd <= 1'b0;
      rx_lag <= 1'b0;
    end else if (CLK_EN_IN) begin
      rx_done <= 1'b0;
      if (dev_rst) begin
        state <= S_IDLE;
        tx_fs_n <= 1'b1;
        rx_fs_n <= 1'b1;
        end_n <= 1'b1;
        rx_lag <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            if (frame_go && wsel_sync[1]) begin
              state <= S_SHIFT;
              bit_cnt <= 4'h0;
              tx_shift <= {ADC_SAMPLE_IN, 2'h0};
              tx_fs_n <= 1'b0;
              rx_fs_n <= async_mode ? rx_lag : 1'b0;
              rx_lag <= ~rx_lag;
              rxd <= ADC_SAMPLE_IN[13];
            end
          end
          S_SHIFT: begin
            if (sclk_rise) begin
              rx_word <= {rx_word[14:0], txd_sync[1]};
            end
            if (sclk_fall) begin
              if (bit_cnt == csl_pkg::LAST_BIT) begin
                state <= S_FRAME_UP;
                tx_fs_n <= 1'b1;
                rx_fs_n <= 1'b1;
                rx_done <= 1'b1;
              end else begin
                bit_cnt <= bit_cnt + 4'h1;
                tx_shift <= {tx_shift[14:0], 1'b0};
                rxd <= tx_shift[14];
              end
            end
          end
          S_FRAME_UP: begin
            if (sclk_fall) begin
              state <= S_END;
              end_n <= 1'b0;
            end
          end
          S_END: begin
            if (sclk_fall) begin
              state <= S_IDLE;
              end_n <= 1'b1;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // Link outputs; frame syncs and end pulses active low
  assign LINK.shift_clk = sclk;
  assign LINK.tx_frame_n = tx_fs_n;
  assign LINK.rx_frame_n = rx_fs_n;
  assign LINK.rx_data = rxd;
  assign LINK.tx_end_n = end_n;
  assign LINK.rx_end_n = end_n;
endmodule
`default_nettype wire

/* csl_pkg.sv */
package csl_pkg;
  // Word format: 14-bit sample above two control bits
  localparam int WORD_W = 16;
  localparam int CTRL_W = 2;
  localparam logic [1:0] ESCAPE_CODE = 2'h3;
  // Secondary control word kinds, selected by the low two bits
  localparam logic [1:0] SEC_RATE_A = 2'h0;
  localparam logic [1:0] SEC_RATE_B = 2'h1;
  localparam logic [1:0] SEC_FILTER = 2'h2;
  localparam logic [1:0] SEC_CONFIG = 2'h3;
  // Config register bits
  localparam int CFG_FILT_BIT = 2;
  localparam int CFG_ASYNC_BIT = 3;
  localparam logic [13:0] CFG_RESET = 14'h0004;
  localparam logic [13:0] RATE_A_RESET = 14'h0012;
  localparam logic [13:0] RATE_B_RESET = 14'h0024;
  // Host-side set-up values
  localparam logic [31:0] TIMER_CTRL_VAL = 32'h000003C1;
  localparam logic [31:0] TIMER_PERIOD_VAL = 32'h00000001;
  localparam logic [31:0] PORT_HOLD_VAL = 32'h02170300;
  localparam logic [31:0] PORT_RUN_VAL = 32'h0E170300;
  localparam logic [31:0] PORT_PIN_VAL = 32'h00000111;
  localparam logic [3:0] FLAG_RESET_LOW = 4'h2;
  localparam logic [3:0] FLAG_RESET_HIGH = 4'h6;
  // Divider settings
  localparam int MCLK_HALF = 1;
  localparam int SCLK_HALF = 4;
  localparam int FRAME_GAP = 64;
  localparam logic [7:0] FRAME_GAP_T = 8'(FRAME_GAP);
  localparam logic [3:0] LAST_BIT = 4'hF;
  // APB map of the host controller
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TXDATA = 8'h04;
  localparam logic [7:0] A_RXDATA = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0C;
  localparam logic [7:0] A_MASK = 8'h10;
  localparam logic [7:0] A_SETUP = 8'h14;
  localparam int ST_RX = 0;
  localparam int ST_TX = 1;
endpackage

/* csl_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface csl_link_if;
  logic master_clk;     // Converter master clock from host
  logic reset_n;        // Converter reset, active low
  logic word_sel;       // High: 16-bit words
  logic shift_clk;      // Serial shift clock from converter
  logic tx_frame_n;     // Frame sync for host-to-converter word
  logic rx_frame_n;     // Frame sync for converter-to-host word
  logic tx_data;        // Host to converter serial data
  logic rx_data;        // Converter to host serial data
  logic tx_end_n;       // End-of-data pulse after transmit
  logic rx_end_n;       // End-of-data pulse after receive
  modport host (output master_clk, reset_n, word_sel, tx_data,
                input shift_clk, tx_frame_n, rx_frame_n, rx_data, tx_end_n, rx_end_n);
  modport dev (input master_clk, reset_n, word_sel, tx_data,
               output shift_clk, tx_frame_n, rx_frame_n, rx_data, tx_end_n, rx_end_n);
endinterface
`default_nettype wire

/* csl_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side: master clock timer, flag-driven reset, serial port, APB registers
module csl_host (
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic CLK_EN_IN,
  csl_link_if.host LINK,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic IRQ_OUT
);
  // Software view of the set-up registers
  logic [3:0] flag_reg;     // Flag register; bit 2 drives converter reset
  logic [31:0] port_ctrl;   // Serial port global control
  logic [15:0] tx_word, rx_word;
  logic [1:0] status, mask;
  logic apb_wr, apb_rd, rx_evt, tx_evt;
  assign apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign apb_rd = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
  assign PREADY_OUT = 1'b1;  // Zero wait states
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & (PADDR_IN > csl_pkg::A_SETUP);

  // Port runs only once software released it; reset bit low holds it
  logic port_run;
  assign port_run = (port_ctrl == csl_pkg::PORT_RUN_VAL);

  // Register writes
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      flag_reg <= csl_pkg::FLAG_RESET_LOW;
      port_ctrl <= csl_pkg::PORT_HOLD_VAL;
      tx_word <= 16'h0;
      mask <= 2'h0;
    end else if (CLK_EN_IN && apb_wr) begin
      case (PADDR_IN)
        // Any word is taken; software keeps both control bits clear for plain data
        csl_pkg::A_TXDATA: tx_word <= PWDATA_IN[15:0];
        csl_pkg::A_CTRL: flag_reg <= PWDATA_IN[3:0];
        csl_pkg::A_SETUP: port_ctrl <= PWDATA_IN;
        csl_pkg::A_MASK: mask <= PWDATA_IN[1:0];
        default: mask <= mask;
      endcase
    end
  end

  // Read data and read-to-clear status; set wins over clear
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      PRDATA_OUT <= 32'h0;
      status <= 2'h0;
    end else if (CLK_EN_IN) begin
      status <= ((apb_rd && PADDR_IN == csl_pkg::A_STATUS) ? 2'h0 : status) | {tx_evt, rx_evt};
      if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
        case (PADDR_IN)
          csl_pkg::A_CTRL: PRDATA_OUT <= {28'h0, flag_reg};
          csl_pkg::A_TXDATA: PRDATA_OUT <= {16'h0, tx_word};
          csl_pkg::A_RXDATA: PRDATA_OUT <= {16'h0, rx_word};
          csl_pkg::A_STATUS: PRDATA_OUT <= {30'h0, status};
          csl_pkg::A_MASK: PRDATA_OUT <= {30'h0, mask};
          csl_pkg::A_SETUP: PRDATA_OUT <= port_ctrl;
          default: PRDATA_OUT <= 32'h0;
        endcase
      end
    end
  end
  assign IRQ_OUT = |(status & mask);

  // Master clock: toggles every second system edge, a quarter of the system rate
  logic [1:0] tdiv;
  logic mclk;
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tdiv <= 2'h0;
      mclk <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (tdiv == 2'(csl_pkg::MCLK_HALF)) begin
        tdiv <= 2'h0;
        mclk <= ~mclk;
      end else begin
        tdiv <= tdiv + 2'h1;
      end
    end
  end
  assign LINK.master_clk = mclk;
  assign LINK.reset_n = flag_reg[2];
  assign LINK.word_sel = 1'b1;

  // Synchronisers for converter pins
  logic [1:0] sclk_s, fsx_s, fsr_s, drx_s;
  logic sclk_prev;
  logic fsx_prev; // Transmit frame, one cycle back
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sclk_s <= 2'h0;
      fsx_s <= 2'h3;
      fsr_s <= 2'h3;
      drx_s <= 2'h0;
      sclk_prev <= 1'b0;
      fsx_prev <= 1'b1;
    end else if (CLK_EN_IN) begin
      sclk_s <= {sclk_s[0], LINK.shift_clk};
      fsx_s <= {fsx_s[0], LINK.tx_frame_n};
      fsr_s <= {fsr_s[0], LINK.rx_frame_n};
      drx_s <= {drx_s[0], LINK.rx_data};
      sclk_prev <= sclk_s[1];
      fsx_prev <= fsx_s[1];
    end
  end

  // Serial port: shift out on falling, sample on rising, frames active low
  logic [15:0] tx_sh, rx_sh;
  logic [4:0] tx_cnt, rx_cnt;
  logic txd;
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tx_sh <= 16'h0;
      rx_sh <= 16'h0;
      tx_cnt <= 5'h0;
      rx_cnt <= 5'h0;
      txd <= 1'b0;
      rx_word <= 16'h0;
      rx_evt <= 1'b0;
      tx_evt <= 1'b0;
    end else if (CLK_EN_IN) begin
      rx_evt <= 1'b0;
      tx_evt <= 1'b0;
      if (!port_run) begin
        tx_cnt <= 5'h0;
        rx_cnt <= 5'h0;
      end else begin
        // The falling edge that opens a frame is no launch: bit 15 already stands
        if (fsx_s[1] || fsx_prev) begin
          // Word done once the frame closes after all fifteen launches
          tx_evt <= fsx_s[1] && (tx_cnt == 5'hF);
          tx_cnt <= 5'h0;
          tx_sh <= tx_word;
          txd <= tx_word[15];
        end else if (sclk_prev && !sclk_s[1] && tx_cnt != 5'hF) begin
          tx_cnt <= tx_cnt + 5'h1;
          tx_sh <= {tx_sh[14:0], 1'b0};
          txd <= tx_sh[14];
        end
        if (fsr_s[1]) begin
          rx_cnt <= 5'h0;
        end else if (!sclk_prev && sclk_s[1] && rx_cnt != 5'h10) begin
          rx_cnt <= rx_cnt + 5'h1;
          rx_sh <= {rx_sh[14:0], drx_s[1]};
          if (rx_cnt == 5'hF) begin
            rx_word <= {rx_sh[14:0], drx_s[1]};
            rx_evt <= 1'b1;
          end
        end
      end
    end
  end
  // Port pins are wired to the serial port for good; no general-purpose pin mode
  assign LINK.tx_data = txd;
endmodule
`default_nettype wire

/* csl_link_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the link wires between the two ends
module csl_link_checker (
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic master_clk,
  input wire logic reset_n,
  input wire logic word_sel,
  input wire logic shift_clk,
  input wire logic tx_frame_n,
  input wire logic rx_frame_n,
  input wire logic tx_end_n,
  input wire logic rx_end_n
);
  localparam int END_WAIT = 100; // Loose bound on end pulse start
  logic sh_q; // Shift clock, one cycle back
  logic mc_q; // Master clock, one cycle back
  logic sh_rise; // Shift clock rose
  logic mc_rise; // Master clock rose
  int pcnt; // Cycles since last shift rise
  int per; // Last shift period in cycles
  int mcnt; // Master rises in this shift period
  int seen; // Shift rises since release
  int tlow; // Transmit frame low count
  int rlow; // Receive frame low count
  int tend; // Transmit end pulse low count
  int rend; // Receive end pulse low count
  assign sh_rise = shift_clk & ~sh_q;
  assign mc_rise = master_clk & ~mc_q;
  // Counters; cleared while the converter is held so a cut word is not judged
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN || !reset_n) begin
      sh_q <= 1'b0;
      mc_q <= 1'b0;
      pcnt <= 0;
      per <= 0;
      mcnt <= 0;
      seen <= 0;
      tlow <= 0;
      rlow <= 0;
      tend <= 0;
      rend <= 0;
    end else begin
      sh_q <= shift_clk;
      mc_q <= master_clk;
      pcnt <= sh_rise ? 1 : pcnt + 1;
      per <= sh_rise ? pcnt : per;
      seen <= (sh_rise && seen < 3) ? seen + 1 : seen;
      mcnt <= sh_rise ? int'(mc_rise) : mcnt + int'(mc_rise);
      tlow <= tx_frame_n ? 0 : tlow + 1;
      rlow <= rx_frame_n ? 0 : rlow + 1;
      tend <= tx_end_n ? 0 : tend + 1;
      rend <= rx_end_n ? 0 : rend + 1;
    end
  end
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  property p_master_duty;
    $rose(master_clk) |=> master_clk ##1 !master_clk ##1 !master_clk ##1 master_clk;
  endproperty
  a_master_duty: assert property (p_master_duty) else $error("master clock shape");
  property p_word_sel;
    word_sel;
  endproperty
  a_word_sel: assert property (p_word_sel) else $error("word select low");
  property p_reset_halt;
    (!reset_n)[*4] |-> tx_frame_n && rx_frame_n && tx_end_n && rx_end_n;
  endproperty
  a_reset_halt: assert property (p_reset_halt) else $error("link active in reset");
  property p_tx_frame_len;
    $rose(tx_frame_n) && seen >= 2 |-> tlow == 16 * per;
  endproperty
  a_tx_frame_len: assert property (p_tx_frame_len) else $error("tx frame length");
  property p_rx_frame_len;
    $rose(rx_frame_n) && seen >= 2 |-> rlow == 16 * per;
  endproperty
  a_rx_frame_len: assert property (p_rx_frame_len) else $error("rx frame length");
  property p_tx_end_len;
    $rose(tx_end_n) && seen >= 2 |-> tend == per;
  endproperty
  a_tx_end_len: assert property (p_tx_end_len) else $error("tx end pulse length");
  property p_rx_end_len;
    $rose(rx_end_n) && seen >= 2 |-> rend == per;
  endproperty
  a_rx_end_len: assert property (p_rx_end_len) else $error("rx end pulse length");
  property p_end_follows;
    $rose(tx_frame_n) && reset_n |-> ##[1:END_WAIT] !tx_end_n;
  endproperty
  a_end_follows: assert property (p_end_follows) else $error("no end pulse");
  property p_shift_ratio;
    sh_rise && seen >= 2 |-> mcnt == 8;
  endproperty
  a_shift_ratio: assert property (p_shift_ratio) else $error("shift divider");
  c_word: cover property ($rose(tx_frame_n));
  c_async: cover property ($fell(tx_frame_n) && rx_frame_n);
  c_hold: cover property ($fell(reset_n));
endmodule
`default_nettype wire

/* codec_serial_link_setup_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module codec_serial_link_setup_tb;
  logic clk = 1'b0; // 100 ns system clock
  logic nrst = 1'b0; // Reset, active low
  logic clk_en = 1'b1; // Clock enable of both ends
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [13:0] adc = 14'h0; // Sample offered by the converter
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [13:0] dac;
  logic dac_stb;
  logic [13:0] cfg;
  logic [13:0] rate_a;
  logic [13:0] rate_b;
  int error_cnt = 0;
  int check_count = 0;
  integer seed = 32'h7DB4;
  logic [31:0] q; // Last read data
  logic err; // Last error response
  csl_link_if link();
  always #50 clk = ~clk;
  csl_host csl_host_inst (.SYS_CLK_IN(clk), .NRST_IN(nrst), .CLK_EN_IN(clk_en), .LINK(link.host),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq));
  csl_dev csl_dev_inst (.SYS_CLK_IN(clk), .NRST_IN(nrst), .CLK_EN_IN(clk_en), .LINK(link.dev),
    .ADC_SAMPLE_IN(adc), .DAC_SAMPLE_OUT(dac), .DAC_STROBE_OUT(dac_stb), .CFG_OUT(cfg),
    .RATE_A_OUT(rate_a), .RATE_B_OUT(rate_b));
  csl_link_checker csl_link_checker_inst (.SYS_CLK_IN(clk), .NRST_IN(nrst),
    .master_clk(link.master_clk), .reset_n(link.reset_n), .word_sel(link.word_sel),
    .shift_clk(link.shift_clk), .tx_frame_n(link.tx_frame_n), .rx_frame_n(link.rx_frame_n),
    .tx_end_n(link.tx_end_n), .rx_end_n(link.rx_end_n));
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Count a comparison, report a miss
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Events the bench waits for
  function automatic logic ev(input int s);
    case (s)
      0: ev = dac_stb;
      1: ev = ~link.rx_end_n;
      2: ev = irq;
      3: ev = link.rx_end_n;
      default: ev = ~link.reset_n;
    endcase
  endfunction
  // Bounded wait; a hang ends the run
  task automatic wait_ev(input int s);
    int n;
    n = 0;
    while (ev(s) !== 1'b1 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 6000) begin
      chk(1'b0, "timeout");
      results();
    end
  endtask
  // One APB transfer, then an idle edge so strobes never toggle twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      chk(1'b0, "bus hang");
      results();
    end
  endtask
  // One word each way, sent in the gap between frames
  task automatic xfer(input logic [15:0] w, input logic play);
    logic [13:0] s;
    wait_ev(1);
    s = 14'($random(seed));
    adc <= s;
    apb(1'b1, csl_pkg::A_TXDATA, {16'h0000, w});
    if (play) begin
      wait_ev(0);
      chk(dac === w[15:2], "sample to converter");
    end
    wait_ev(2);
    // Transmit flag comes as the frame closes; the end pulse follows both
    wait_ev(1);
    chk(irq === 1'b1, "interrupt raised");
    apb(1'b0, csl_pkg::A_STATUS, 32'h0);
    chk(q[csl_pkg::ST_RX] === 1'b1 && q[csl_pkg::ST_TX] === 1'b1, "done flags");
    apb(1'b0, csl_pkg::A_RXDATA, 32'h0);
    chk(q[15:2] === s, "sample from converter");
    apb(1'b0, csl_pkg::A_STATUS, 32'h0);
    chk(q === 32'h0 && irq === 1'b0, "flags cleared by read");
  endtask
  // Expected register after a secondary word
  function automatic logic sec_ok(input int k, input logic [13:0] v, input logic [13:0] o);
    case (k)
      0: sec_ok = rate_a === v;
      1: sec_ok = rate_b === v;
      2: sec_ok = cfg === {o[13:3], v[2], o[1:0]};
      default: sec_ok = cfg === v;
    endcase
  endfunction
  initial begin
    logic [15:0] w;
    logic [13:0] v;
    logic [13:0] old;
    int n;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(link.reset_n === 1'b0 && link.tx_frame_n === 1'b1, "converter held");
    chk(cfg === csl_pkg::CFG_RESET && rate_a === csl_pkg::RATE_A_RESET, "defaults");
    apb(1'b0, 8'h18, 32'h0);
    chk(err === 1'b1, "unmapped address");
    apb(1'b1, csl_pkg::A_SETUP, csl_pkg::PORT_HOLD_VAL);
    apb(1'b1, csl_pkg::A_MASK, 32'h3);
    apb(1'b1, csl_pkg::A_SETUP, csl_pkg::PORT_RUN_VAL);
    apb(1'b1, csl_pkg::A_CTRL, {28'h0, csl_pkg::FLAG_RESET_HIGH});
    chk(link.reset_n === 1'b1, "converter released");
    $display("done: set-up");
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 16'hFFFC : (i == 1) ? 16'h0000 : {14'($random(seed)), 2'b00};
      xfer(w, 1'b1);
    end
    $display("done: data words");
    apb(1'b1, csl_pkg::A_MASK, 32'h0);
    wait_ev(3);
    wait_ev(1);
    chk(irq === 1'b0, "masked interrupt");
    apb(1'b0, csl_pkg::A_STATUS, 32'h0);
    chk(q[csl_pkg::ST_RX] === 1'b1, "status while masked");
    apb(1'b1, csl_pkg::A_MASK, 32'h3);
    $display("done: mask");
    for (int k = 0; k < 4; k++) begin
      v = 14'($random(seed));
      v[csl_pkg::CFG_ASYNC_BIT] = (k == 3) ? 1'b0 : v[csl_pkg::CFG_ASYNC_BIT];
      old = cfg;
      xfer({14'($random(seed)), csl_pkg::ESCAPE_CODE}, 1'b1);
      xfer({v, 2'(k)}, 1'b0);
      chk(sec_ok(k, v, old), "secondary load");
    end
    $display("done: secondary words");
    xfer({14'($random(seed)), csl_pkg::ESCAPE_CODE}, 1'b1);
    xfer({14'h0008, csl_pkg::SEC_CONFIG}, 1'b0);
    chk(cfg[csl_pkg::CFG_ASYNC_BIT] === 1'b1, "async selected");
    // Plain word from now on, so repeated frames never carry an escape
    apb(1'b1, csl_pkg::A_TXDATA, 32'h0);
    n = 0;
    for (int i = 0; i < 5000; i++) begin
      @(posedge clk);
      n += (!link.tx_frame_n && link.rx_frame_n) ? 1 : 0;
    end
    chk(n > 0, "frames apart");
    $display("done: async");
    apb(1'b1, csl_pkg::A_CTRL, {28'h0, csl_pkg::FLAG_RESET_LOW});
    wait_ev(4);
    // Let the converter's own reset take hold
    repeat (4) @(posedge clk);
    chk(cfg === csl_pkg::CFG_RESET && rate_b === csl_pkg::RATE_B_RESET, "defaults again");
    apb(1'b1, csl_pkg::A_CTRL, {28'h0, csl_pkg::FLAG_RESET_HIGH});
    xfer({14'($random(seed)), 2'b00}, 1'b1);
    chk(cfg === csl_pkg::CFG_RESET && rate_a === csl_pkg::RATE_A_RESET, "defaults kept");
    $display("done: converter reset");
    results();
  end
endmodule
`default_nettype wire
